// *** alr_pkg.sv ***
`default_nettype none
// ==========================================================
// Shared constants for the ambient light readout block
package alr_pkg;
  // ==========================================================
  // Target address (7-bit, R/W appended gives 26h / 27h)
  localparam logic [6:0] ALR_I2C_ADDR = 7'h13;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] ALR_REG_COMMAND = 8'h80;
  localparam logic [7:0] ALR_REG_LED_CURRENT = 8'h83;
  localparam logic [7:0] ALR_REG_ALS_CONFIG = 8'h84;
  localparam logic [7:0] ALR_REG_RESULT_HIGH = 8'h85;
  localparam logic [7:0] ALR_REG_RESULT_LOW = 8'h86;

  // ==========================================================
  // Field positions
  localparam int ALR_CMD_PERIODIC_BIT = 2;
  localparam int ALR_CMD_ONESHOT_BIT = 4;
  localparam int ALR_CMD_READY_BIT = 6;
  localparam int ALR_CFG_CONTINUOUS_BIT = 7;
  localparam int ALR_CFG_AVG_LSB = 0;
  localparam int ALR_LED_CURRENT_W = 6;

  // ==========================================================
  // Reset values
  localparam logic [7:0] ALR_COMMAND_RESET = 8'h00;
  localparam logic [7:0] ALR_CONFIG_RESET = 8'h00;
  localparam logic [5:0] ALR_LED_CURRENT_RESET = 6'h00;

  // ==========================================================
  // Timing: figures in their own units, counts derived at 100 MHz
  localparam int ALR_CLK_HZ = 100000000;
  localparam int ALR_FRAME_MS = 100;
  localparam int ALR_CONV_US = 300;
  localparam int ALR_FRAME_CYCLES = (ALR_CLK_HZ / 1000) * ALR_FRAME_MS;
  localparam int ALR_CONV_CYCLES = (ALR_CLK_HZ / 1000000) * ALR_CONV_US;
endpackage
`default_nettype wire

// *** alr_meas_if.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Control and result link between register file and sequencer
interface alr_meas_if;
  logic req;
  logic continuous;
  logic [2:0] avg_sel;
  logic busy;
  logic conv;
  logic done;
  logic [15:0] result;
  modport ctrl (output req, output continuous, output avg_sel, input busy, input conv, input done, input result);
  modport seq (input req, input continuous, input avg_sel, output busy, output conv, output done, output result);
endinterface
`default_nettype wire

// *** alr_pin_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Three-stage pin synchroniser with agreement filter
module alr_pin_sync
#(
  parameter int W = 2
)
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [W-1:0] i_pin,
  output logic [W-1:0] o_level
);
  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : gen_bit
      logic s1;
      logic s2;
      logic s3;
      // Stage one feeds stage two only; level moves when two and three agree
      always_ff @(posedge i_ref_clk)
      begin
        if (!i_rst_n)
        begin
          s1 <= 1'b1;
          s2 <= 1'b1;
          s3 <= 1'b1;
          o_level[g] <= 1'b1;
        end
        else if (i_ce)
        begin
          s1 <= i_pin[g];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3)
          begin
            o_level[g] <= s3;
          end
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// *** alr_als_seq.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Ambient light conversion sequencer with averaging
module alr_als_seq
  import alr_pkg::*;
#(
  parameter int FRAME_CYCLES = ALR_FRAME_CYCLES,
  parameter int CONV_CYCLES = ALR_CONV_CYCLES
)
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [15:0] i_light_level,
  alr_meas_if.seq m
);
  typedef enum logic [1:0] {
    ALR_SEQ_IDLE = 2'b00,
    ALR_SEQ_CONV = 2'b01,
    ALR_SEQ_WAIT = 2'b10
  } alr_seq_state_t;

  alr_seq_state_t state;
  logic [31:0] frame_cnt;
  logic [31:0] conv_cnt;
  logic [7:0] samples;
  logic [22:0] accum;
  logic [7:0] target;
  logic conv_end;
  logic last_sample;

  assign target = 8'h01 << m.avg_sel;
  assign conv_end = (conv_cnt == 32'(CONV_CYCLES - 1));
  assign last_sample = (samples == target - 8'h01);
  assign m.busy = (state != ALR_SEQ_IDLE);
  assign m.conv = (state == ALR_SEQ_CONV);

  // ==========================================================
  // Frame timer runs from the first sample of every measurement
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      frame_cnt <= '0;
    else if (i_ce)
      frame_cnt <= (state == ALR_SEQ_IDLE) ? 32'h0000_0000 : frame_cnt + 32'h0000_0001;
  end

  // ==========================================================
  // Sample timing, accumulation and result publication
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      state <= ALR_SEQ_IDLE;
      conv_cnt <= '0;
      samples <= '0;
      accum <= '0;
      m.done <= 1'b0;
      m.result <= 16'h0000;
    end
    else if (i_ce)
    begin
      m.done <= 1'b0;
      unique case (state)
        ALR_SEQ_IDLE:
        begin
          conv_cnt <= '0;
          samples <= '0;
          accum <= '0;
          // One-shot flag clears a cycle after done, so skip that cycle
          if (m.req && !m.done)
            state <= ALR_SEQ_CONV;
        end
        ALR_SEQ_CONV:
        begin
          conv_cnt <= conv_end ? 32'h0000_0000 : conv_cnt + 32'h0000_0001;
          if (conv_end)
          begin
            accum <= accum + 23'(i_light_level);
            samples <= samples + 8'h01;
            if (last_sample)
            begin
              if (m.continuous)
              begin
                // mean published at once in continuous mode
                m.result <= 16'((accum + 23'(i_light_level)) >> m.avg_sel);
                m.done <= 1'b1;
                state <= ALR_SEQ_IDLE;
              end
              else
                state <= ALR_SEQ_WAIT;
            end
            // next sample starts with no gap
          end
        end
        ALR_SEQ_WAIT:
        begin
          if (frame_cnt >= 32'(FRAME_CYCLES - 1))
          begin
            // accumulator holds the full sum while waiting
            m.result <= 16'(accum >> m.avg_sel);
            m.done <= 1'b1;
            state <= ALR_SEQ_IDLE;
          end
        end
        default:
          state <= ALR_SEQ_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** alr_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module alr_top
  import alr_pkg::*;
#(
  parameter int FRAME_CYCLES = ALR_FRAME_CYCLES,
  parameter int CONV_CYCLES = ALR_CONV_CYCLES
)
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic [15:0] i_light_level,
  output logic o_sda_out,
  output logic o_sda_oe_n,
  output logic o_standby,
  output logic o_als_conv_en,
  output logic o_led_sink_en,
  output logic [5:0] o_led_current
);
  typedef enum logic [3:0] {
    ALR_I2C_IDLE = 4'b0000,
    ALR_I2C_ADDR = 4'b0001,
    ALR_I2C_ADDR_ACK = 4'b0010,
    ALR_I2C_PTR = 4'b0011,
    ALR_I2C_PTR_ACK = 4'b0100,
    ALR_I2C_WDATA = 4'b0101,
    ALR_I2C_WDATA_ACK = 4'b0110,
    ALR_I2C_RDATA = 4'b0111,
    ALR_I2C_RACK = 4'b1000
  } alr_i2c_state_t;

  alr_meas_if meas ();

  // ==========================================================
  // Pin conditioning
  logic [1:0] pins;
  logic scl;
  logic sda;
  logic scl_d;
  logic sda_d;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  alr_pin_sync #(.W(2)) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_pin({i_scl, i_sda}),
    .o_level(pins)
  );

  assign scl = pins[1];
  assign sda = pins[0];

  // Previous levels for edge and condition detection
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else if (i_ce)
    begin
      scl_d <= scl;
      sda_d <= sda;
    end
  end

  assign scl_rise = scl & ~scl_d;
  assign scl_fall = ~scl & scl_d;
  // start and repeated start look alike
  assign start_cond = scl & scl_d & sda_d & ~sda;
  assign stop_cond = scl & scl_d & ~sda_d & sda;

  // ==========================================================
  // Register state
  logic [7:0] ptr;
  logic periodic_en;
  logic oneshot_pend;
  logic data_ready;
  logic [7:0] als_config;
  logic [5:0] led_current;
  logic wr_stb;
  logic rd_done_stb;
  logic [7:0] rx_byte;

  // Register read decode, shared by load of first and later bytes
  function automatic logic [7:0] reg_read(input logic [7:0] addr);
    logic [7:0] v;
    v = 8'h00;
    unique case (addr)
      ALR_REG_COMMAND:
      begin
        v[ALR_CMD_PERIODIC_BIT] = periodic_en;
        v[ALR_CMD_ONESHOT_BIT] = oneshot_pend;
        v[ALR_CMD_READY_BIT] = data_ready;
      end
      ALR_REG_LED_CURRENT:
        v = {2'b00, led_current};
      ALR_REG_ALS_CONFIG:
        v = als_config;
      ALR_REG_RESULT_HIGH:
        v = meas.result[15:8];
      ALR_REG_RESULT_LOW:
        v = meas.result[7:0];
      default:
        v = 8'h00;
    endcase
    return v;
  endfunction

  // ==========================================================
  // I2C target state machine
  alr_i2c_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] tx_byte;
  logic read_dir;
  logic host_nack;
  logic drive_low;
  logic [7:0] rd_next;

  // Byte that the pointer addresses, loaded at each read byte start
  assign rd_next = reg_read(ptr);

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      state <= ALR_I2C_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      tx_byte <= 8'h00;
      read_dir <= 1'b0;
      host_nack <= 1'b0;
      drive_low <= 1'b0;
    end
    else if (i_ce)
    begin
      if (stop_cond)
      begin
        state <= ALR_I2C_IDLE;
        drive_low <= 1'b0;
      end
      else if (start_cond)
      begin
        state <= ALR_I2C_ADDR;
        bit_cnt <= 4'h0;
        drive_low <= 1'b0;
      end
      else if (scl_rise)
      begin
        // Data is sampled on the rising clock edge
        unique case (state)
          ALR_I2C_ADDR, ALR_I2C_PTR, ALR_I2C_WDATA:
          begin
            shift <= {shift[6:0], sda};
            bit_cnt <= bit_cnt + 4'h1;
          end
          ALR_I2C_RDATA:
            bit_cnt <= bit_cnt + 4'h1;
          ALR_I2C_RACK:
            host_nack <= sda;
          default:
            bit_cnt <= bit_cnt;
        endcase
      end
      else if (scl_fall)
      begin
        // Drive changes only while the clock is low
        unique case (state)
          ALR_I2C_IDLE:
            drive_low <= 1'b0;
          ALR_I2C_ADDR:
            if (bit_cnt == 4'h8)
            begin
              // match 26h write and 27h read
              if (shift[7:1] == alr_pkg::ALR_I2C_ADDR)
              begin
                state <= ALR_I2C_ADDR_ACK;
                read_dir <= shift[0];
                drive_low <= 1'b1;
              end
              else
                state <= ALR_I2C_IDLE;
            end
          ALR_I2C_ADDR_ACK:
          begin
            bit_cnt <= 4'h0;
            if (read_dir)
            begin
              state <= ALR_I2C_RDATA;
              tx_byte <= rd_next;
              drive_low <= ~rd_next[7];
            end
            else
            begin
              state <= ALR_I2C_PTR;
              drive_low <= 1'b0;
            end
          end
          ALR_I2C_PTR, ALR_I2C_WDATA:
            if (bit_cnt == 4'h8)
            begin
              state <= (state == ALR_I2C_PTR) ? ALR_I2C_PTR_ACK : ALR_I2C_WDATA_ACK;
              drive_low <= 1'b1;
            end
          ALR_I2C_PTR_ACK, ALR_I2C_WDATA_ACK:
          begin
            state <= ALR_I2C_WDATA;
            bit_cnt <= 4'h0;
            drive_low <= 1'b0;
          end
          ALR_I2C_RDATA:
            if (bit_cnt == 4'h8)
            begin
              state <= ALR_I2C_RACK;
              drive_low <= 1'b0;
            end
            else
              drive_low <= ~tx_byte[3'(4'h7 - bit_cnt)];
          ALR_I2C_RACK:
          begin
            bit_cnt <= 4'h0;
            if (host_nack)
            begin
              state <= ALR_I2C_IDLE;
              drive_low <= 1'b0;
            end
            else
            begin
              // Pointer already moved on, so this is the next register
              state <= ALR_I2C_RDATA;
              tx_byte <= rd_next;
              drive_low <= ~rd_next[7];
            end
          end
          default:
            state <= ALR_I2C_IDLE;
        endcase
      end
    end
  end

  // Byte events that touch the register file
  assign wr_stb = scl_fall & ~stop_cond & ~start_cond & (state == ALR_I2C_WDATA) & (bit_cnt == 4'h8);
  assign rd_done_stb = scl_fall & ~stop_cond & ~start_cond & (state == ALR_I2C_RDATA) & (bit_cnt == 4'h8);
  assign rx_byte = shift;

  // ==========================================================
  // Register pointer
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      ptr <= 8'h00;
    else if (i_ce)
    begin
      if (scl_fall & ~stop_cond & ~start_cond & (state == ALR_I2C_PTR) & (bit_cnt == 4'h8))
        ptr <= rx_byte;
      else if (rd_done_stb | wr_stb)
        ptr <= ptr + 8'h01;
    end
  end

  // ==========================================================
  // Writable registers
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      periodic_en <= ALR_COMMAND_RESET[ALR_CMD_PERIODIC_BIT];
      als_config <= ALR_CONFIG_RESET;
      led_current <= ALR_LED_CURRENT_RESET;
    end
    else if (i_ce && wr_stb)
    begin
      unique case (ptr)
        ALR_REG_COMMAND:
          periodic_en <= rx_byte[ALR_CMD_PERIODIC_BIT];
        ALR_REG_LED_CURRENT:
          led_current <= rx_byte[ALR_LED_CURRENT_W-1:0];
        ALR_REG_ALS_CONFIG:
          als_config <= rx_byte;
        default:
          als_config <= als_config;
      endcase
    end
  end

  // One-shot request: software sets, completion clears, a new set wins
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      oneshot_pend <= 1'b0;
    else if (i_ce)
    begin
      if (wr_stb && ptr == ALR_REG_COMMAND && rx_byte[ALR_CMD_ONESHOT_BIT])
        oneshot_pend <= 1'b1;
      else if (meas.done)
        oneshot_pend <= 1'b0;
    end
  end

  // Ready flag: set by a new result, cleared by reading the low byte; set wins
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      data_ready <= 1'b0;
    else if (i_ce)
    begin
      if (meas.done)
        data_ready <= 1'b1;
      else if (rd_done_stb && ptr == ALR_REG_RESULT_LOW)
        data_ready <= 1'b0;
    end
  end

  // ==========================================================
  // Measurement sequencer
  assign meas.req = periodic_en | oneshot_pend;
  assign meas.continuous = als_config[ALR_CFG_CONTINUOUS_BIT];
  assign meas.avg_sel = als_config[ALR_CFG_AVG_LSB +: 3];

  alr_als_seq #(
    .FRAME_CYCLES(FRAME_CYCLES),
    .CONV_CYCLES(CONV_CYCLES)
  ) u_seq (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_light_level(i_light_level),
    .m(meas.seq)
  );

  // ==========================================================
  // Registered outputs
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      o_sda_out <= 1'b0;
      o_sda_oe_n <= 1'b1;
      o_standby <= 1'b1;
      o_als_conv_en <= 1'b0;
      o_led_sink_en <= 1'b0;
      o_led_current <= 6'h00;
    end
    else if (i_ce)
    begin
      // Open drain: only ever pulls low
      o_sda_out <= 1'b0;
      o_sda_oe_n <= ~drive_low;
      o_standby <= ~(meas.req | meas.busy);
      o_als_conv_en <= meas.conv;
      // sink off in standby, setting kept
      o_led_sink_en <= (meas.req | meas.busy) & (led_current != 6'h00);
      o_led_current <= (meas.req | meas.busy) ? led_current : 6'h00;
    end
  end
endmodule
`default_nettype wire

// *** alr_top_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Port checks for the ambient light readout block
module alr_top_properties
  import alr_pkg::*;
#(
  parameter int FRAME_CYCLES = ALR_FRAME_CYCLES,
  parameter int CONV_CYCLES = ALR_CONV_CYCLES
)
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic [15:0] i_light_level,
  input wire logic o_sda_out,
  input wire logic o_sda_oe_n,
  input wire logic o_standby,
  input wire logic o_als_conv_en,
  input wire logic o_led_sink_en,
  input wire logic [5:0] o_led_current
);
  int run_cnt;

  // ==========================================================
  // Length of the running conversion burst, cleared while the enable is low
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n || !o_als_conv_en)
      run_cnt <= 0;
    else if (i_ce)
      run_cnt <= run_cnt + 1;
  end

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  // ==========================================================
  // open drain, standby, LED sink and conversion burst
  a_sda_never_high: assert property (o_sda_out == 1'h0)
    else $error("sda data output driven high");
  a_drive_scl_low: assert property ($changed(o_sda_oe_n) |-> !i_scl)
    else $error("sda drive changed while scl high");
  a_standby_no_conv: assert property (o_standby && $past(o_standby) |-> !o_als_conv_en)
    else $error("conversion running in standby");
  a_standby_sink_off: assert property (o_standby |-> !o_led_sink_en && o_led_current == 6'h00)
    else $error("led sink active in standby");
  a_sink_has_current: assert property (o_led_sink_en |-> o_led_current != 6'h00)
    else $error("led sink on with zero current");
  a_sample_whole: assert property ($fell(o_als_conv_en) |-> run_cnt != 0 && run_cnt % CONV_CYCLES == 0)
    else $error("conversion burst not whole samples");
  a_avg_cap: assert property (run_cnt <= 128 * CONV_CYCLES && run_cnt < FRAME_CYCLES)
    else $error("conversion burst too long");
  a_start_prompt: assert property ($fell(o_standby) |-> ##[0:6] o_als_conv_en)
    else $error("no conversion after leaving standby");
endmodule

bind alr_top alr_top_properties #(.FRAME_CYCLES(FRAME_CYCLES), .CONV_CYCLES(CONV_CYCLES)) alr_top_properties_i (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_scl(i_scl), .i_sda(i_sda),
  .i_light_level(i_light_level), .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n), .o_standby(o_standby),
  .o_als_conv_en(o_als_conv_en), .o_led_sink_en(o_led_sink_en), .o_led_current(o_led_current));
`default_nettype wire

// *** alr_i2c_host.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Bus host model driving the target port
module alr_i2c_host
(
  input wire logic i_ref_clk,
  input wire logic i_sda_line,
  output logic o_scl,
  output logic o_sda
);
  // Idle bus sits released high
  initial
  begin
    o_scl = 1'h1;
    o_sda = 1'h1;
  end

  // Eight clocks per phase keeps both SCL levels above six
  task automatic half();
    repeat (8) @(posedge i_ref_clk);
  endtask

  task automatic start();
    o_sda <= 1'h1;
    half();
    o_scl <= 1'h1;
    half();
    o_sda <= 1'h0;
    half();
    o_scl <= 1'h0;
    half();
  endtask

  task automatic stop();
    o_sda <= 1'h0;
    half();
    o_scl <= 1'h1;
    half();
    o_sda <= 1'h1;
    half();
  endtask

  // whole bytes
  // Nine bits MSB first; SDA moves mid low phase, never near the SCL edges
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--)
    begin
      o_sda <= d[i];
      half();
      o_scl <= 1'h1;
      half();
      q[i] = i_sda_line;
      o_scl <= 1'h0;
      half();
    end
  endtask
endmodule
`default_nettype wire

// *** alr_top_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Self-checking bench for the ambient light readout block
module alr_top_tb_top;
  import alr_pkg::*;
  localparam int FRAME = 3000;
  localparam int CONV = 20;
  typedef struct packed {logic cont; logic [2:0] avg; logic [15:0] light; logic [11:0] exp_conv;} alr_row_t;
  logic clk, rst_n, ce, scl, host_sda, sda_out, sda_oe_n, standby, conv_en, sink_en;
  logic [15:0] light;
  logic [5:0] led_cur;
  wire sda_line;
  int error_cnt = 0;
  int check_count = 0;
  int busy_cyc = 0;
  int conv_cyc = 0;
  alr_row_t rows [9] = '{'{1'h0, 3'h0, 16'h1234, 12'h014}, '{1'h1, 3'h1, 16'hABCD, 12'h028},
    '{1'h0, 3'h2, 16'h00FF, 12'h050}, '{1'h1, 3'h3, 16'hFF00, 12'h0A0}, '{1'h0, 3'h4, 16'h8001, 12'h140},
    '{1'h1, 3'h5, 16'h7FFE, 12'h280}, '{1'h0, 3'h6, 16'h0F0F, 12'h500}, '{1'h1, 3'h7, 16'hC3A5, 12'hA00},
    '{1'h0, 3'h7, 16'h5A3C, 12'hA00}};

  // Pull-up wired with the open-drain target
  assign sda_line = host_sda & sda_oe_n;

  // 100 MHz clock
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  alr_top #(.FRAME_CYCLES(FRAME), .CONV_CYCLES(CONV)) alr_top_i (.i_ref_clk(clk), .i_rst_n(rst_n), .i_ce(ce),
    .i_scl(scl), .i_sda(sda_line), .i_light_level(light), .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n),
    .o_standby(standby), .o_als_conv_en(conv_en), .o_led_sink_en(sink_en), .o_led_current(led_cur));
  alr_i2c_host alr_i2c_host_i (.i_ref_clk(clk), .i_sda_line(sda_line), .o_scl(scl), .o_sda(host_sda));

  // Tallies of busy and converting cycles, read as differences
  always @(posedge clk)
  begin
    busy_cyc <= busy_cyc + int'(!standby);
    conv_cyc <= conv_cyc + int'(conv_en);
  end

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] ptr, input logic [7:0] d);
    logic [8:0] q;
    alr_i2c_host_i.start();
    alr_i2c_host_i.xfer({8'h26, 1'h1}, q);
    check(16'(q[0]), 16'h0000, "write address ack");
    alr_i2c_host_i.xfer({ptr, 1'h1}, q);
    alr_i2c_host_i.xfer({d, 1'h1}, q);
    check(16'(q[0]), 16'h0000, "data ack");
    alr_i2c_host_i.stop();
  endtask

  // Pointer write, then three bytes read; rs picks repeated start over stop
  task automatic rd3(input logic [7:0] ptr, input logic rs, input logic [23:0] exp);
    logic [8:0] q;
    alr_i2c_host_i.start();
    alr_i2c_host_i.xfer({8'h26, 1'h1}, q);
    alr_i2c_host_i.xfer({ptr, 1'h1}, q);
    if (!rs)
      alr_i2c_host_i.stop();
    alr_i2c_host_i.start();
    alr_i2c_host_i.xfer({8'h27, 1'h1}, q);
    check(16'(q[0]), 16'h0000, "read address ack");
    for (int i = 0; i < 3; i++)
    begin
      alr_i2c_host_i.xfer({8'hFF, i == 2}, q);
      check(16'(q[8:1]), 16'(exp[23 - 8 * i -: 8]), "read byte");
    end
    alr_i2c_host_i.stop();
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    int b0, c0, lo, hi;
    logic [8:0] q;
    rst_n = 1'h0;
    ce = 1'h1;
    light = 16'h0000;
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    repeat (8) @(posedge clk);
    check({12'h000, standby, sda_oe_n, sink_en, conv_en}, 16'h000C, "reset outputs");
    wr_reg(8'h83, 8'h15);
    check({10'h000, led_cur}, 16'h0000, "standby led current");
    $display("test reset done");
    foreach (rows[r])
    begin
      light <= rows[r].light;
      wr_reg(8'h84, {rows[r].cont, 4'h0, rows[r].avg});
      b0 = busy_cyc;
      c0 = conv_cyc;
      wr_reg(8'h80, 8'h10);
      for (int k = 0; k < FRAME + 100 && standby !== 1'h1; k++)
        @(posedge clk);
      repeat (4) @(posedge clk);
      lo = rows[r].cont ? int'(rows[r].exp_conv) : FRAME - 4;
      hi = rows[r].cont ? int'(rows[r].exp_conv) + 16 : FRAME + 8;
      check(16'(conv_cyc - c0), 16'(rows[r].exp_conv), "sample cycles");
      check(16'(busy_cyc - b0 >= lo && busy_cyc - b0 <= hi), 16'h0001, "measurement span");
      rd3(8'h84, r[0], {rows[r].cont, 4'h0, rows[r].avg, rows[r].light});
      $display("test row %0d done", r);
    end
    // Read-only write ignored, pointer runs on into an unmapped place
    wr_reg(8'h85, 8'hA5);
    rd3(8'h85, 1'h1, {16'h5A3C, 8'h00});
    alr_i2c_host_i.start();
    alr_i2c_host_i.xfer({8'h30, 1'h1}, q);
    check(16'(q[0]), 16'h0001, "foreign address nack");
    alr_i2c_host_i.stop();
    $display("test readonly and address done");
    // Framed result must hold the old value until the frame ends
    light <= 16'h9696;
    wr_reg(8'h84, 8'h00);
    wr_reg(8'h80, 8'h10);
    check({8'h00, standby, sink_en, led_cur}, 16'h0055, "active led drive");
    rd3(8'h84, 1'h0, {8'h00, 16'h5A3C});
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge clk);
    check({8'h00, standby, sink_en, led_cur}, 16'h0080, "standby after reset");
    $display("test frame hold and reset done");
    complete_run();
  end

  // Watchdog: the sequence needs about 50000 cycles, so twice that means a hang
  initial
  begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    complete_run();
  end
endmodule
`default_nettype wire
